/* verilog/gpio_defs.svh */
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

// Register bus geometry
`define GPIO_ADDR_W 4
`define GPIO_PINS 16
`define GPIO_GROUP_PINS 8

// Register byte addresses
`define GPIO_GROUP_A_OFFSET 4'h0
`define GPIO_GROUP_C_OFFSET 4'h4

// Field positions inside each control register (lsb of an 8-bit field)
`define GPIO_FLD_MODE 24
`define GPIO_FLD_DIR 16
`define GPIO_FLD_SF 8
`define GPIO_FLD_DATA 0

// Byte lane of each field
`define GPIO_LANE_MODE 3
`define GPIO_LANE_DIR 2
`define GPIO_LANE_SF 1
`define GPIO_LANE_DATA 0

// Reset values, group A: every pin a plain input
`define GPIO_A_MODE_RST 8'h00
`define GPIO_A_DIR_RST 8'h00
`define GPIO_A_DATA_RST 8'h00

// Reset values, group C: LED pins 6, 4, 2 outputs, red lit, others dark
`define GPIO_C_MODE_RST 8'h00
`define GPIO_C_DIR_RST 8'h54
`define GPIO_C_SF_RST 8'h00
`define GPIO_C_DATA_RST 8'h14

// Bus answers
`define GPIO_RESP_OKAY 2'b00
`define GPIO_RESP_SLVERR 2'b10

`endif

/* verilog/gpio_pkg.sv */
package gpio_pkg;

    typedef logic [7:0] pin_byte_t;
    typedef logic [15:0] pin_vec_t;

    // How one pin is used, decoded from its three configuration bits
    typedef enum logic [1:0] {
        USE_INPUT,
        USE_OUTPUT,
        USE_PERIPH
    } pin_use_t;

endpackage : gpio_pkg

/* verilog/pin_bank_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface pin_bank_if;
    import gpio_pkg::*;

    pin_vec_t mode;
    pin_vec_t dir;
    pin_vec_t sf;
    pin_vec_t data;
    pin_vec_t periph_out;
    pin_vec_t periph_drive;
    pin_vec_t pin_out;
    pin_vec_t pin_oe_n;

    modport ctrl (
        output mode,
        output dir,
        output sf,
        output data,
        output periph_out,
        output periph_drive,
        input pin_out,
        input pin_oe_n
    );

    modport drive (
        input mode,
        input dir,
        input sf,
        input data,
        input periph_out,
        input periph_drive,
        output pin_out,
        output pin_oe_n
    );
endinterface : pin_bank_if

`default_nettype wire

/* verilog/pin_drive.sv */
`include "gpio_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module pin_drive (
    input wire logic CLK,
    input wire logic RST,
    pin_bank_if.drive bank
);
    import gpio_pkg::*;

    // Three configuration bits to a pin use
    function automatic pin_use_t decode_use(input logic mode, input logic dir, input logic sf);
        if (mode || sf) begin
            decode_use = USE_PERIPH;
        end else if (dir) begin
            decode_use = USE_OUTPUT;
        end else begin
            decode_use = USE_INPUT;
        end
    endfunction : decode_use

    pin_vec_t nxt_out;
    pin_vec_t nxt_oe_n;
    pin_vec_t out_ff;
    pin_vec_t oe_n_ff;

    // Per-pin source of level and enable
    always_comb begin
        nxt_out = '0;
        nxt_oe_n = '1;
        for (int i = 0; i < `GPIO_PINS; i++) begin
            unique case (decode_use(bank.mode[i], bank.dir[i], bank.sf[i]))
                // R5: plain input
                USE_INPUT: begin
                    nxt_out[i] = 1'b0;
                    nxt_oe_n[i] = 1'b1;
                end
                // R6: plain output
                // R4: data drives pin
                USE_OUTPUT: begin
                    nxt_out[i] = bank.data[i];
                    nxt_oe_n[i] = 1'b0;
                end
                // R18: peripheral owns pin
                USE_PERIPH: begin
                    nxt_out[i] = bank.periph_out[i];
                    nxt_oe_n[i] = ~bank.periph_drive[i];
                end
                default: begin
                    nxt_out[i] = 1'b0;
                    nxt_oe_n[i] = 1'b1;
                end
            endcase
        end
    end

    // Registered pad drive; released to input while in reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            out_ff <= '0;
            oe_n_ff <= '1;
        end else begin
            out_ff <= nxt_out;
            oe_n_ff <= nxt_oe_n;
        end
    end

    assign bank.pin_out = out_ff;
    assign bank.pin_oe_n = oe_n_ff;
endmodule : pin_drive

`default_nettype wire

/* verilog/gpio_port_config.sv */
// Function
// R1: Sixteen pins controlled through two registers of eight pins each.
// R2: Each pin has mode, direction, special function and data bits. Group A pins have no special function bit; it is fixed at zero.
// R3: Reading a data bit returns the present pin level.
// R4: Writing a data bit sets the level driven on an output pin.
// R5: Mode, direction and special function all zero make a plain input.
// R6: Mode zero, direction one, special function zero make a plain output.
// R7: Software should read-modify-write the whole word to change one pin.
// R8: Software must not reconfigure reserved pins, including group C pins 1-0.
// R9: One of the two shared header pins must stay an input.
// R10: Serial use: upper shared pin drives RTS, lower is plain input.
// R11: SPI use: upper shared pin plain input, lower delivers SPI clock.
// R12: LED pins must stay outputs.
// R13: LEDs light when their pin is driven low.
// R14: Red LED pin is driven lit by default as power indicator.
// R15: Button pin is configured as plain input.
// R16: Serial pins may be switched to plain input or output.
// R17: Button line reads high when released, low when pressed.
// R18: Nonzero mode or special function hands the pin to its peripheral.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "gpio_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module gpio_port_config (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [`GPIO_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [`GPIO_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire gpio_pkg::pin_vec_t PIN_IN,
    output gpio_pkg::pin_vec_t PIN_OUT,
    output gpio_pkg::pin_vec_t PIN_OE_N,
    input wire gpio_pkg::pin_vec_t PERIPH_OUT,
    input wire gpio_pkg::pin_vec_t PERIPH_DRIVE,
    output gpio_pkg::pin_vec_t PERIPH_IN
);
    import gpio_pkg::*;

    // Byte-lane merge used for every writable field
    function automatic pin_byte_t merge_lane(input pin_byte_t old, input logic [31:0] wd,
                                             input logic en, input int lsb);
        merge_lane = en ? wd[lsb +: 8] : old;
    endfunction : merge_lane

    // Word address to register select
    function automatic logic [1:0] decode_reg(input logic [`GPIO_ADDR_W-1:0] addr);
        decode_reg = 2'b00;
        if ({addr[`GPIO_ADDR_W-1:2], 2'b00} == `GPIO_GROUP_A_OFFSET) begin
            decode_reg = 2'b01;
        end else if ({addr[`GPIO_ADDR_W-1:2], 2'b00} == `GPIO_GROUP_C_OFFSET) begin
            decode_reg = 2'b10;
        end
    endfunction : decode_reg

    // Bus channel state
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [`GPIO_ADDR_W-1:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;

    // Configuration registers; group A has no special-function byte
    pin_byte_t a_mode_ff;
    pin_byte_t a_dir_ff;
    pin_byte_t a_data_ff;
    pin_byte_t c_mode_ff;
    pin_byte_t c_dir_ff;
    pin_byte_t c_sf_ff;
    pin_byte_t c_data_ff;

    // Pin synchronisers
    pin_vec_t pin_meta_ff;
    pin_vec_t pin_sync_ff;
    pin_vec_t periph_in_ff;

    logic aw_fire;
    logic w_fire;
    logic wr_go;
    logic ar_fire;
    logic [1:0] wr_sel;
    logic [1:0] rd_sel;

    assign aw_fire = S_AXI_AWVALID && awready_ff;
    assign w_fire = S_AXI_WVALID && wready_ff;
    assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
    assign ar_fire = S_AXI_ARVALID && arready_ff;
    assign wr_sel = decode_reg(waddr_ff);
    assign rd_sel = decode_reg(S_AXI_ARADDR);

    // Write address and data are caught independently, in either order
    always_ff @(posedge CLK) begin
        if (RST) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            waddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (aw_fire) begin
                awready_ff <= 1'b0;
                aw_got_ff <= 1'b1;
                waddr_ff <= S_AXI_AWADDR;
            end
            if (w_fire) begin
                wready_ff <= 1'b0;
                w_got_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
            end
            // Ready returns only after the response, so one write at a time
            if (bvalid_ff && S_AXI_BREADY) begin
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // Write response; unmapped words answer SLVERR and change nothing
    always_ff @(posedge CLK) begin
        if (RST) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `GPIO_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wr_sel == 2'b00) ? `GPIO_RESP_SLVERR : `GPIO_RESP_OKAY;
        end else if (bvalid_ff && S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    // R1: group A register
    // R2: config bytes plus data; group A has no special-function byte
    // R14: red LED lit at reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            a_mode_ff <= `GPIO_A_MODE_RST;
            a_dir_ff <= `GPIO_A_DIR_RST;
            a_data_ff <= `GPIO_A_DATA_RST;
            c_mode_ff <= `GPIO_C_MODE_RST;
            c_dir_ff <= `GPIO_C_DIR_RST;
            c_sf_ff <= `GPIO_C_SF_RST;
            c_data_ff <= `GPIO_C_DATA_RST;
        end else if (wr_go && wr_sel == 2'b01) begin
            a_mode_ff <= merge_lane(a_mode_ff, wdata_ff, wstrb_ff[`GPIO_LANE_MODE], `GPIO_FLD_MODE);
            a_dir_ff <= merge_lane(a_dir_ff, wdata_ff, wstrb_ff[`GPIO_LANE_DIR], `GPIO_FLD_DIR);
            // R4: write output level
            a_data_ff <= merge_lane(a_data_ff, wdata_ff, wstrb_ff[`GPIO_LANE_DATA], `GPIO_FLD_DATA);
        end else if (wr_go && wr_sel == 2'b10) begin
            // R1: group C register
            c_mode_ff <= merge_lane(c_mode_ff, wdata_ff, wstrb_ff[`GPIO_LANE_MODE], `GPIO_FLD_MODE);
            c_dir_ff <= merge_lane(c_dir_ff, wdata_ff, wstrb_ff[`GPIO_LANE_DIR], `GPIO_FLD_DIR);
            c_sf_ff <= merge_lane(c_sf_ff, wdata_ff, wstrb_ff[`GPIO_LANE_SF], `GPIO_FLD_SF);
            c_data_ff <= merge_lane(c_data_ff, wdata_ff, wstrb_ff[`GPIO_LANE_DATA], `GPIO_FLD_DATA);
        end
    end

    // Two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge CLK) begin
        if (RST) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end else begin
            pin_meta_ff <= PIN_IN;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Synchronised levels handed to the peripherals
    always_ff @(posedge CLK) begin
        if (RST) begin
            periph_in_ff <= '0;
        end else begin
            periph_in_ff <= pin_sync_ff;
        end
    end

    // Read channel; data bits show the pin, not the stored output value
    always_ff @(posedge CLK) begin
        if (RST) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rresp_ff <= `GPIO_RESP_OKAY;
            rdata_ff <= '0;
        end else if (ar_fire) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= (rd_sel == 2'b00) ? `GPIO_RESP_SLVERR : `GPIO_RESP_OKAY;
            rdata_ff <= '0;
            // R3: data reads pin level
            // R17: button level passes unaltered
            if (rd_sel == 2'b01) begin
                rdata_ff <= {a_mode_ff, a_dir_ff, 8'h00, pin_sync_ff[7:0]};
            end else if (rd_sel == 2'b10) begin
                rdata_ff <= {c_mode_ff, c_dir_ff, c_sf_ff, pin_sync_ff[15:8]};
            end
        end else if (rvalid_ff && S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    pin_bank_if bank ();

    // R2: special function only in group C
    assign bank.mode = {c_mode_ff, a_mode_ff};
    assign bank.dir = {c_dir_ff, a_dir_ff};
    assign bank.sf = {c_sf_ff, 8'h00};
    assign bank.data = {c_data_ff, a_data_ff};
    assign bank.periph_out = PERIPH_OUT;
    assign bank.periph_drive = PERIPH_DRIVE;

    // R16: per-pin mux between serial peripheral and plain use
    pin_drive u_drive (
        .CLK(CLK),
        .RST(RST),
        .bank(bank.drive)
    );

    assign PIN_OUT = bank.pin_out;
    assign PIN_OE_N = bank.pin_oe_n;
    assign PERIPH_IN = periph_in_ff;
    assign S_AXI_AWREADY = awready_ff;
    assign S_AXI_WREADY = wready_ff;
    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;
    assign S_AXI_ARREADY = arready_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RRESP = rresp_ff;
    assign S_AXI_RDATA = rdata_ff;
endmodule : gpio_port_config

`default_nettype wire

/* testbench/gpio_checker.sv */
`include "gpio_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module gpio_checker (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [`GPIO_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [`GPIO_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire gpio_pkg::pin_vec_t PIN_IN,
    input wire gpio_pkg::pin_vec_t PIN_OUT,
    input wire gpio_pkg::pin_vec_t PIN_OE_N,
    input wire gpio_pkg::pin_vec_t PERIPH_IN
);
    import gpio_pkg::*;
    logic [2:0] age_ff;

    // Cycles since reset; saturates so it never wraps back to look fresh
    always_ff @(posedge CLK) begin
        if (RST) begin
            age_ff <= 3'h0;
        end else if (age_ff != 3'h7) begin
            age_ff <= age_ff + 3'h1;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    // Both write channels taken, and a read address taken
    sequence s_wr;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_rd;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    // Pads quiet long enough for every synchroniser stage to agree
    sequence s_calm;
        $stable(PIN_IN)[*4] ##0 (age_ff == 3'h7);
    endsequence

    property p_wr_ok;
        s_wr ##0 !S_AXI_AWADDR[3] |=> ##1 S_AXI_BVALID && !S_AXI_AWREADY && S_AXI_BRESP == `GPIO_RESP_OKAY;
    endproperty
    a_wr_ok: assert property (p_wr_ok) else $error("write answer wrong");
    property p_wr_bad;
        s_wr ##0 S_AXI_AWADDR[3] |=> ##1 S_AXI_BVALID && S_AXI_BRESP == `GPIO_RESP_SLVERR;
    endproperty
    a_wr_bad: assert property (p_wr_bad) else $error("unmapped write accepted");
    property p_b_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_rd_bad;
        s_rd ##0 S_AXI_ARADDR[3] |=> S_AXI_RVALID && S_AXI_RRESP == `GPIO_RESP_SLVERR && S_AXI_RDATA == 32'h0;
    endproperty
    a_rd_bad: assert property (p_rd_bad) else $error("unmapped read accepted");
    property p_rd_pins;
        s_calm ##0 s_rd ##0 (S_AXI_ARADDR[3:2] == 2'h0) |=>
            {8'h0, S_AXI_RDATA[7:0]} == ($past(PIN_IN) & 16'h00ff);
    endproperty
    a_rd_pins: assert property (p_rd_pins) else $error("read data not pad level");
    property p_sync;
        s_calm |-> PERIPH_IN == PIN_IN;
    endproperty
    a_sync: assert property (p_sync) else $error("pad level not passed on");
    property p_led_reset;
        age_ff == 3'h2 |-> PIN_OE_N == 16'habff && (PIN_OUT[15:8] & 8'h54) == 8'h14;
    endproperty
    a_led_reset: assert property (p_led_reset) else $error("lamp pins wrong after reset");
endmodule : gpio_checker

bind gpio_port_config gpio_checker chk (.CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
    .PIN_IN, .PIN_OUT, .PIN_OE_N, .PERIPH_IN);

`default_nettype wire

/* testbench/board_model.sv */
`timescale 1ns/1ns
`default_nettype none

module board_model (
    input wire gpio_pkg::pin_vec_t lvl,
    input wire gpio_pkg::pin_vec_t off_n,
    input wire gpio_pkg::pin_vec_t x_val,
    input wire gpio_pkg::pin_vec_t x_en,
    output gpio_pkg::pin_vec_t pad,
    output logic clash,
    output logic [2:0] led_lit
);
    import gpio_pkg::*;
    logic shared;

    // two pins on one header pin
    assign shared = !off_n[5] ? lvl[5] : !off_n[4] ? lvl[4] : x_en[4] ? x_val[4] : 1'b1;
    assign clash = !off_n[5] && !off_n[4];

    // undriven lines float high through pull-ups
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pad[i] = !off_n[i] ? lvl[i] : x_en[i] ? x_val[i] : 1'b1;
        end
        pad[5] = shared;
        pad[4] = shared;
    end

    // lamps light on a low level
    assign led_lit = ~{pad[14], pad[12], pad[10]};
endmodule : board_model

`default_nettype wire

/* testbench/module_gpio_port_config_test.sv */
`timescale 1ns/1ns
`default_nettype none

module module_gpio_port_config_test;
    import gpio_pkg::*;
    logic clk = 1'b0, rst = 1'b1;
    logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
    logic [3:0] aw_addr = 4'h0, ar_addr = 4'h0, w_strb = 4'h0;
    logic [31:0] w_data = 32'h0, r_data;
    logic [1:0] b_resp, r_resp;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, clash;
    logic [2:0] led_lit;
    pin_vec_t pin_in, pin_out, pin_oe_n, p_in;
    pin_vec_t p_out = 16'h0, p_drv = 16'h0, x_val = 16'h0, x_en = 16'h0;
    int num_errors = 0, tests_run = 0;

    gpio_port_config dut (.CLK(clk), .RST(rst), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
        .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid),
        .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
        .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
        .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .PERIPH_OUT(p_out), .PERIPH_DRIVE(p_drv), .PERIPH_IN(p_in));
    board_model board (.lvl(pin_out), .off_n(pin_oe_n), .x_val(x_val), .x_en(x_en), .pad(pin_in),
        .clash(clash), .led_lit(led_lit));

    // Free-running 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("%0d compares, %0d mismatches", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask : check

    // A bound that ran out means the slave never answered
    task automatic give_up(input int n);
        if (n >= 40) begin
            num_errors++;
            $display("unexpected at %0t: no bus answer", $time);
            tally_and_finish();
        end
    endtask : give_up

    // Ready is raised late on purpose so the answer must wait
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        aw_addr <= a;
        w_data <= d;
        w_strb <= s;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (b_valid && b_ready) break;
            if (aw_valid && aw_ready) aw_valid <= 1'b0;
            if (w_valid && w_ready) w_valid <= 1'b0;
            if (b_valid) b_ready <= 1'b1;
        end
        give_up(n);
        r = b_resp;
        b_ready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        ar_addr <= a;
        ar_valid <= 1'b1;
        for (n = 0; n < 40 && !(ar_valid && ar_ready); n++) @(posedge clk);
        give_up(n);
        ar_valid <= 1'b0;
        @(posedge clk);
        r_ready <= 1'b1;
        for (n = 0; n < 40 && !(r_valid && r_ready); n++) @(posedge clk);
        give_up(n);
        d = r_data;
        r = r_resp;
        r_ready <= 1'b0;
    endtask : rd

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rd(4'h0, d, r);
        check(d, 32'h0000_00ff);
        rd(4'h4, d, r);
        check(d, 32'h0054_00bf);
        check(32'(led_lit), 32'h4);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_output();
        logic [31:0] d;
        logic [1:0] r;
        wr(4'h0, 32'h0081_ff80, 4'hf, r);
        check(32'({pin_oe_n[7:0], pin_out[7], pin_out[0]}), 32'h1fa);
        repeat (3) @(posedge clk);
        rd(4'h0, d, r);
        check(d, 32'h0081_00fe);
        rd(4'h4, d, r);
        wr(4'h4, d & 32'hffff_fffb, 4'hf, r);
        check(32'({pin_oe_n[15:8], led_lit}), 32'h55d);
        $display("t_output done");
    endtask : t_output

    task automatic t_input();
        logic [31:0] d;
        logic [1:0] r;
        x_en <= 16'h2000;
        repeat (4) @(posedge clk);
        check(32'(p_in[13]), 32'h0);
        rd(4'h4, d, r);
        check(d, 32'h0054_009b);
        x_en <= 16'h0;
        repeat (4) @(posedge clk);
        check(32'(p_in[13]), 32'h1);
        $display("t_input done");
    endtask : t_input

    task automatic t_periph();
        logic [1:0] r;
        p_out <= 16'h0020;
        p_drv <= 16'h0020;
        wr(4'h0, 32'h2000_0000, 4'hf, r);
        check(32'({pin_oe_n[5:4], pin_out[5], clash}), 32'h6);
        wr(4'h4, 32'h00d4_00bb, 4'hf, r);
        check(32'({pin_oe_n[15], pin_out[15]}), 32'h1);
        wr(4'h4, 32'h00d4_80bb, 4'hf, r);
        check(32'(pin_oe_n[15]), 32'h1);
        p_out <= 16'h8020;
        p_drv <= 16'h8020;
        repeat (2) @(posedge clk);
        check(32'({pin_oe_n[15], pin_out[15]}), 32'h1);
        p_out <= 16'h8010;
        p_drv <= 16'h8010;
        wr(4'h0, 32'h1000_0000, 4'hf, r);
        check(32'({pin_oe_n[5:4], pin_out[4], clash}), 32'ha);
        $display("t_periph done");
    endtask : t_periph

    task automatic t_bus();
        logic [31:0] d;
        logic [1:0] r;
        wr(4'h8, 32'hffff_ffff, 4'hf, r);
        check(32'(r), 32'h2);
        rd(4'hc, d, r);
        check(32'(r), 32'h2);
        check(d, 32'h0);
        wr(4'h4, 32'hffff_ff00, 4'h1, r);
        check(32'({pin_oe_n[15:8], led_lit}), 32'h15f);
        $display("t_bus done");
    endtask : t_bus

    // Main sequence; the first request waits until the pad synchronisers hold real levels
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_output();
        t_input();
        t_periph();
        t_bus();
        tally_and_finish();
    end
endmodule : module_gpio_port_config_test

`default_nettype wire
